// File: design/bsbtse_pkg.sv
// Overview of operation
// - skip-if-clear skips next when bit is zero
// - taken skip-if-clear discards prefetch, runs no-operation
// - skip-if-set skips next when bit is one
// - taken skip-if-set costs two cycles, untaken one
// - bit-set forces selected bit to one, one cycle
package bsbtse_pkg;

  localparam int unsigned INSTR_W = 14;
  localparam int unsigned ADDR_W  = 7;
  localparam int unsigned BIT_W   = 3;
  localparam int unsigned DATA_W  = 8;

  // field positions inside the instruction word
  localparam int unsigned ADDR_LSB = 0;
  localparam int unsigned BIT_LSB  = 7;
  localparam int unsigned OPC_LSB  = 10;
  localparam int unsigned OPC_W    = 4;

  // opcode nibbles: 01 01, 01 10, 01 11
  localparam logic [OPC_W-1:0] OPC_BIT_SET        = 4'h5;
  localparam logic [OPC_W-1:0] OPC_TEST_SKIP_CLR  = 4'h6;
  localparam logic [OPC_W-1:0] OPC_TEST_SKIP_SET  = 4'h7;

  // reset values
  localparam logic [ADDR_W-1:0] RST_ADDR = 7'h00;
  localparam logic [BIT_W-1:0]  RST_BIT  = 3'h0;
  localparam logic [DATA_W-1:0] RST_DATA = 8'h00;

  typedef enum logic [1:0] {
    OP_NONE,
    OP_BIT_SET_IN_REGISTER,
    OP_BIT_TEST_SKIP_IF_CLEAR,
    OP_BIT_TEST_SKIP_IF_SET
  } bsbtse_op_e;

  function automatic logic [DATA_W-1:0] bsbtse_bit_mask(input logic [BIT_W-1:0] sel);
    bsbtse_bit_mask = 8'h01 << sel;
  endfunction

endpackage

// File: design/bsbtse_decode.sv
`timescale 1ns/1ps
module bsbtse_decode (
  // instruction word
  input  wire logic [bsbtse_pkg::INSTR_W-1:0] instr_i,
  // decoded fields
  output bsbtse_pkg::bsbtse_op_e              op_o,
  output logic      [bsbtse_pkg::ADDR_W-1:0]  addr_o,
  output logic      [bsbtse_pkg::BIT_W-1:0]   bit_o
);

  logic [bsbtse_pkg::OPC_W-1:0] opc;

  assign opc    = instr_i[bsbtse_pkg::OPC_LSB +: bsbtse_pkg::OPC_W];
  assign addr_o = instr_i[bsbtse_pkg::ADDR_LSB +: bsbtse_pkg::ADDR_W];
  assign bit_o  = instr_i[bsbtse_pkg::BIT_LSB +: bsbtse_pkg::BIT_W];

  always_comb begin
    case (opc)
      bsbtse_pkg::OPC_BIT_SET:       op_o = bsbtse_pkg::OP_BIT_SET_IN_REGISTER;
      bsbtse_pkg::OPC_TEST_SKIP_CLR: op_o = bsbtse_pkg::OP_BIT_TEST_SKIP_IF_CLEAR;
      bsbtse_pkg::OPC_TEST_SKIP_SET: op_o = bsbtse_pkg::OP_BIT_TEST_SKIP_IF_SET;
      default:                       op_o = bsbtse_pkg::OP_NONE;
    endcase
  end

endmodule // bsbtse_decode

// File: design/bsbtse_core.sv
`timescale 1ns/1ps
module bsbtse_core (
  // clock and reset
  input  wire logic                            clk_sys_i,
  input  wire logic                            rst_i,
  // instruction from fetch stage
  input  wire logic                            instr_valid_i,
  input  wire logic [bsbtse_pkg::INSTR_W-1:0]  instr_i,
  // register file read port
  output logic      [bsbtse_pkg::ADDR_W-1:0]   rf_raddr_o,
  input  wire logic [bsbtse_pkg::DATA_W-1:0]   rf_rdata_i,
  // register file write port
  output logic                                 rf_we_o,
  output logic      [bsbtse_pkg::ADDR_W-1:0]   rf_waddr_o,
  output logic      [bsbtse_pkg::DATA_W-1:0]   rf_wdata_o,
  // sequencing to fetch stage
  output logic                                 skip_o,
  output logic                                 nop_o,
  output logic                                 done_o
);

  bsbtse_pkg::bsbtse_op_e            dec_op;
  logic [bsbtse_pkg::ADDR_W-1:0]     dec_addr;
  logic [bsbtse_pkg::BIT_W-1:0]      dec_bit;

  bsbtse_pkg::bsbtse_op_e            ex_op;
  logic [bsbtse_pkg::BIT_W-1:0]      ex_bit;
  logic                              ex_nop;
  logic                              kill_pend;
  logic [bsbtse_pkg::DATA_W-1:0]     opnd;
  logic                              sel_bit;
  logic                              taken;
  logic                              kill_now;

  bsbtse_decode u_decode (
    .instr_i (instr_i),
    .op_o    (dec_op),
    .addr_o  (dec_addr),
    .bit_o   (dec_bit)
  );

  // forward a pending write so back-to-back access to one register sees fresh data
  assign opnd    = (rf_we_o && (rf_waddr_o == rf_raddr_o)) ? rf_wdata_o : rf_rdata_i;
  assign sel_bit = |(opnd & bsbtse_pkg::bsbtse_bit_mask(ex_bit));

  always_comb begin
    case (ex_op)
      bsbtse_pkg::OP_BIT_TEST_SKIP_IF_CLEAR: taken = ~sel_bit;
      bsbtse_pkg::OP_BIT_TEST_SKIP_IF_SET:   taken = sel_bit;
      default:                               taken = 1'b0;
    endcase
  end

  // the kill waits for the next fetched word when fetch stalls behind the test
  assign kill_now = taken | kill_pend;

  // execute stage: the fetched word after a taken test becomes a no-operation
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      ex_op      <= bsbtse_pkg::OP_NONE;
      ex_nop     <= 1'b0;
      ex_bit     <= bsbtse_pkg::RST_BIT;
      rf_raddr_o <= bsbtse_pkg::RST_ADDR;
    end else begin
      ex_op  <= (instr_valid_i && !kill_now) ? dec_op : bsbtse_pkg::OP_NONE;
      ex_nop <= instr_valid_i && kill_now;
      if (instr_valid_i) begin
        rf_raddr_o <= dec_addr;
        ex_bit     <= dec_bit;
      end
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      kill_pend <= 1'b0;
    end else begin
      kill_pend <= kill_now && !instr_valid_i;
    end
  end

  // write-back: read-modify-write leaves unselected bits alone, no flag port exists
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      rf_we_o    <= 1'b0;
      rf_waddr_o <= bsbtse_pkg::RST_ADDR;
      rf_wdata_o <= bsbtse_pkg::RST_DATA;
    end else begin
      rf_we_o    <= (ex_op == bsbtse_pkg::OP_BIT_SET_IN_REGISTER);
      rf_waddr_o <= rf_raddr_o;
      rf_wdata_o <= opnd | bsbtse_pkg::bsbtse_bit_mask(ex_bit);
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      skip_o <= 1'b0;
      nop_o  <= 1'b0;
      done_o <= 1'b0;
    end else begin
      skip_o <= taken;
      nop_o  <= ex_nop;
      done_o <= (ex_op != bsbtse_pkg::OP_NONE);
    end
  end

  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (rst_i);

  sequence s_clr_zero;
    ex_op == bsbtse_pkg::OP_BIT_TEST_SKIP_IF_CLEAR && !sel_bit;
  endsequence

  sequence s_set_one;
    ex_op == bsbtse_pkg::OP_BIT_TEST_SKIP_IF_SET && sel_bit;
  endsequence

  sequence s_discard;
    (skip_o && ex_op == bsbtse_pkg::OP_NONE) ##1 nop_o;
  endsequence

  // a kill armed behind a stalled fetch lands on whichever word comes next
  sequence s_late_discard;
    (ex_op == bsbtse_pkg::OP_NONE && !kill_pend) ##1 (nop_o && !done_o && !rf_we_o);
  endsequence

  // the forward path is what lets a test right behind a bit set see the new bit
  sequence s_same_bit_just_set;
    (ex_op == bsbtse_pkg::OP_BIT_SET_IN_REGISTER) ##1
      (rf_raddr_o == $past(rf_raddr_o) && ex_bit == $past(ex_bit));
  endsequence

  sequence s_single_slot;
    (done_o && !skip_o) ##1 !nop_o;
  endsequence

  chk_clear_skip: assert property (s_clr_zero |=> skip_o)
    else $error("skip-if-clear with zero bit did not skip");

  chk_clear_no_skip: assert property (
    (ex_op == bsbtse_pkg::OP_BIT_TEST_SKIP_IF_CLEAR && sel_bit) |=> !skip_o)
    else $error("skip-if-clear with one bit skipped");

  chk_clear_discard: assert property (s_clr_zero ##0 instr_valid_i |=> s_discard)
    else $error("taken skip-if-clear did not replace next word with no-operation");

  chk_set_skip: assert property (
    (ex_op == bsbtse_pkg::OP_BIT_TEST_SKIP_IF_SET) |=> (skip_o == $past(sel_bit)))
    else $error("skip-if-set decision wrong");

  chk_set_discard: assert property (s_set_one ##0 instr_valid_i |=> s_discard)
    else $error("taken skip-if-set did not replace next word with no-operation");

  chk_untaken_one: assert property (
    (ex_op inside {bsbtse_pkg::OP_BIT_TEST_SKIP_IF_CLEAR, bsbtse_pkg::OP_BIT_TEST_SKIP_IF_SET}
     && !taken) |=> (done_o && !skip_o) ##1 !nop_o)
    else $error("untaken bit test took an extra cycle");

  chk_bit_set_write: assert property (
    (ex_op == bsbtse_pkg::OP_BIT_SET_IN_REGISTER) |=>
      (rf_we_o && done_o && rf_waddr_o == $past(rf_raddr_o)
       && (rf_wdata_o & bsbtse_pkg::bsbtse_bit_mask($past(ex_bit))) != 8'h00))
    else $error("bit-set did not write selected bit in one cycle");

  chk_addr_field: assert property (
    (instr_valid_i && !kill_now && dec_op != bsbtse_pkg::OP_NONE) |=>
      (rf_raddr_o == $past(instr_i[6:0]) && ex_op != bsbtse_pkg::OP_NONE))
    else $error("register address not taken from low seven bits");

  chk_other_bits: assert property (
    (ex_op == bsbtse_pkg::OP_BIT_SET_IN_REGISTER) |=>
      ((rf_wdata_o & ~bsbtse_pkg::bsbtse_bit_mask($past(ex_bit)))
       == ($past(opnd) & ~bsbtse_pkg::bsbtse_bit_mask($past(ex_bit)))))
    else $error("bit-set disturbed unselected bits");

  chk_test_no_write: assert property (
    (ex_op != bsbtse_pkg::OP_BIT_SET_IN_REGISTER) |=> !rf_we_o)
    else $error("register written by a non-set instruction");

  chk_stall_arm: assert property ((taken && !instr_valid_i) |=> kill_pend)
    else $error("taken test with stalled fetch did not arm the kill");

  chk_stall_discard: assert property (
    (kill_pend && instr_valid_i) |=> s_late_discard)
    else $error("late word after a taken test was not discarded");

  chk_killed_quiet: assert property (
    (instr_valid_i && kill_now) |-> ##2 (nop_o && !done_o && !rf_we_o && !skip_o))
    else $error("discarded word completed, wrote or skipped");

  chk_nop_alone: assert property (nop_o |-> (!done_o && !rf_we_o))
    else $error("no-operation slot also completed an instruction");

  chk_fwd_clear: assert property (
    (s_same_bit_just_set ##0 (ex_op == bsbtse_pkg::OP_BIT_TEST_SKIP_IF_CLEAR)) |=> !skip_o)
    else $error("skip-if-clear missed a bit set just before it");

  chk_fwd_set: assert property (
    (s_same_bit_just_set ##0 (ex_op == bsbtse_pkg::OP_BIT_TEST_SKIP_IF_SET)) |=> skip_o)
    else $error("skip-if-set missed a bit set just before it");

  chk_set_single: assert property (
    (ex_op == bsbtse_pkg::OP_BIT_SET_IN_REGISTER) |=> s_single_slot)
    else $error("bit-set did not finish in a single slot");

  chk_done_follows: assert property (
    (instr_valid_i && !kill_now && dec_op != bsbtse_pkg::OP_NONE) |-> ##2 done_o)
    else $error("accepted bit instruction never completed");

  // other opcodes belong to the rest of the core; they must pass through untouched
  chk_foreign_ignored: assert property (
    (instr_valid_i && !kill_now && dec_op == bsbtse_pkg::OP_NONE)
      |-> ##2 (!done_o && !rf_we_o && !skip_o))
    else $error("foreign opcode was acted upon");

  chk_raddr_hold: assert property (!instr_valid_i |=> $stable(rf_raddr_o))
    else $error("read address moved without a new word");

  // the default disable would hide reset itself, so it is switched off here
  chk_reset_idle: assert property (disable iff (1'b0)
    rst_i |=> (!rf_we_o && !skip_o && !nop_o && !done_o))
    else $error("outputs not idle after a reset edge");

endmodule // bsbtse_core

// File: bench/bsbtse_rf_model.sv
`timescale 1ns/1ps
module bsbtse_rf_model (
  // clock
  input  wire logic       clk_sys_i,
  // read port
  input  wire logic [6:0] raddr_i,
  output logic      [7:0] rdata_o,
  // write port
  input  wire logic       we_i,
  input  wire logic [6:0] waddr_i,
  input  wire logic [7:0] wdata_i
);
  logic [7:0] mem [128];
  // each register starts at its own address, so the bench knows every operand
  initial begin
    for (int i = 0; i < 128; i++) begin
      mem[i] = 8'(i);
    end
  end
  // read must be combinational, the core samples it in the same cycle
  assign rdata_o = mem[raddr_i];
  // plain always: the initial block above also writes this array
  always @(posedge clk_sys_i) begin
    if (we_i) begin
      mem[waddr_i] <= wdata_i;
    end
  end
endmodule // bsbtse_rf_model

// File: bench/bit_set_and_bit_test_skip_exec_tb_top.sv
`timescale 1ns/1ps
module bit_set_and_bit_test_skip_exec_tb_top;
  logic        clk_sys_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        instr_valid_i = 1'b0;
  logic [13:0] instr_i = 14'h0000;
  logic [6:0]  rf_raddr_o;
  logic [6:0]  rf_waddr_o;
  logic [7:0]  rf_rdata_i;
  logic [7:0]  rf_wdata_o;
  logic        rf_we_o;
  logic        skip_o;
  logic        nop_o;
  logic        done_o;
  int          fail_count = 0;
  int          n_tests = 0;
  int          cyc = 0;
  int          k = 0;
  always #5 clk_sys_i = ~clk_sys_i;
  bsbtse_core dut_u (.clk_sys_i(clk_sys_i), .rst_i(rst_i),
    .instr_valid_i(instr_valid_i), .instr_i(instr_i), .rf_raddr_o(rf_raddr_o),
    .rf_rdata_i(rf_rdata_i), .rf_we_o(rf_we_o), .rf_waddr_o(rf_waddr_o),
    .rf_wdata_o(rf_wdata_o), .skip_o(skip_o), .nop_o(nop_o), .done_o(done_o));
  bsbtse_rf_model rf_u (.clk_sys_i(clk_sys_i), .raddr_i(rf_raddr_o),
    .rdata_o(rf_rdata_i), .we_i(rf_we_o), .waddr_i(rf_waddr_o),
    .wdata_i(rf_wdata_o));
  task automatic finish_test;
    $display("checks %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fail_count++;
      $display("CHECK FAILED at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // one instruction, then a bit set straight behind it that a taken test must kill
  task automatic run(input logic [3:0] op, input logic [2:0] b, input logic [6:0] a,
                     input logic tk, input logic [7:0] wd);
    logic [6:0] a1;
    a1 = 7'(7'h20 + 2 * k);
    k++;
    instr_valid_i = 1'b1;
    instr_i = {op, b, a};
    @(negedge clk_sys_i);
    instr_i = {4'h5, 3'h0, a1};
    chk(8'(rf_raddr_o), 8'(a));
    @(negedge clk_sys_i);
    instr_valid_i = 1'b0;
    chk(8'(done_o), 8'h01);
    chk(8'(skip_o), 8'(tk));
    chk(8'(rf_we_o), 8'(op == 4'h5));
    if (op == 4'h5) begin
      chk(rf_wdata_o, wd);
      chk(8'(rf_waddr_o), 8'(a));
    end
    @(negedge clk_sys_i);
    chk(8'(nop_o), 8'(tk));
    chk(8'(done_o), 8'(!tk));
    chk(8'(rf_we_o), 8'(!tk));
    if (!tk) begin
      chk(rf_wdata_o, {1'b0, a1} | 8'h01);
    end
    repeat (2) @(negedge clk_sys_i);
    $display("test done op %h addr %h", op, a);
  endtask
  // fetch stalls one cycle behind a taken test: the next word that comes is killed
  task automatic stall_skip;
    instr_valid_i = 1'b1;
    instr_i = {4'h7, 3'h6, 7'h40};
    @(negedge clk_sys_i);
    instr_valid_i = 1'b0;
    @(negedge clk_sys_i);
    instr_valid_i = 1'b1;
    instr_i = {4'h5, 3'h0, 7'h40};
    chk(8'(skip_o), 8'h01);
    @(negedge clk_sys_i);
    instr_valid_i = 1'b0;
    chk(8'(done_o | nop_o), 8'h00);
    @(negedge clk_sys_i);
    chk(8'(nop_o), 8'h01);
    chk(8'(done_o | rf_we_o), 8'h00);
    repeat (2) @(negedge clk_sys_i);
    $display("test done stalled skip");
  endtask
  // a bit set straight before a skip-if-set of that bit is only seen through the forward
  task automatic fwd_set_skip;
    instr_valid_i = 1'b1;
    instr_i = {4'h5, 3'h3, 7'h30};
    @(negedge clk_sys_i);
    instr_i = {4'h7, 3'h3, 7'h30};
    @(negedge clk_sys_i);
    instr_i = {4'h5, 3'h0, 7'h30};
    chk(rf_wdata_o, 8'h38);
    @(negedge clk_sys_i);
    instr_valid_i = 1'b0;
    chk(8'(skip_o), 8'h01);
    @(negedge clk_sys_i);
    chk(8'(nop_o), 8'h01);
    chk(8'(rf_we_o), 8'h00);
    repeat (2) @(negedge clk_sys_i);
    $display("test done forward then skip-if-set");
  endtask
  // a fresh bit keeps skip-if-clear from skipping; a word of another opcode is not ours
  task automatic fwd_clear_foreign;
    instr_valid_i = 1'b1;
    instr_i = {4'h5, 3'h0, 7'h32};
    @(negedge clk_sys_i);
    instr_i = {4'h6, 3'h0, 7'h32};
    @(negedge clk_sys_i);
    instr_i = {4'h4, 3'h0, 7'h32};
    chk(rf_wdata_o, 8'h33);
    @(negedge clk_sys_i);
    instr_valid_i = 1'b0;
    chk(8'(skip_o), 8'h00);
    chk(8'(done_o), 8'h01);
    @(negedge clk_sys_i);
    chk(8'(done_o | rf_we_o | nop_o), 8'h00);
    repeat (2) @(negedge clk_sys_i);
    $display("test done forward then skip-if-clear, foreign opcode");
  endtask
  // a reset while a kill is armed must drop it; the word after release runs normally
  task automatic reset_mid;
    instr_valid_i = 1'b1;
    instr_i = {4'h6, 3'h0, 7'h50};
    @(negedge clk_sys_i);
    instr_valid_i = 1'b0;
    @(negedge clk_sys_i);
    rst_i = 1'b1;
    repeat (2) @(negedge clk_sys_i);
    rst_i = 1'b0;
    chk(8'(skip_o | done_o | nop_o | rf_we_o), 8'h00);
    instr_valid_i = 1'b1;
    instr_i = {4'h5, 3'h2, 7'h50};
    @(negedge clk_sys_i);
    instr_valid_i = 1'b0;
    @(negedge clk_sys_i);
    chk(8'(rf_we_o & done_o), 8'h01);
    chk(rf_wdata_o, 8'h54);
    @(negedge clk_sys_i);
    chk(8'(nop_o), 8'h00);
    repeat (2) @(negedge clk_sys_i);
    $display("test done reset in mid-run");
  endtask
  // the whole sequence needs well under a hundred cycles
  always @(posedge clk_sys_i) begin
    cyc++;
    if (cyc == 2000) begin
      fail_count++;
      finish_test();
    end
  end
  initial begin
    repeat (12) @(negedge clk_sys_i);
    rst_i = 1'b0;
    @(negedge clk_sys_i);
    chk(8'(done_o | skip_o | rf_we_o), 8'h00);
    run(4'h5, 3'h7, 7'h12, 1'b0, 8'h92);
    run(4'h6, 3'h0, 7'h12, 1'b1, 8'h00);
    run(4'h6, 3'h1, 7'h12, 1'b0, 8'h00);
    run(4'h7, 3'h6, 7'h7F, 1'b1, 8'h00);
    run(4'h7, 3'h0, 7'h00, 1'b0, 8'h00);
    stall_skip();
    fwd_set_skip();
    fwd_clear_foreign();
    reset_mid();
    finish_test();
  end
endmodule // bit_set_and_bit_test_skip_exec_tb_top
